// ---- bench/dual_clock_fifo_prog_flags_tb_top.sv ----
// ==========================================================
// Testbench
module dual_clock_fifo_prog_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic write_enable_n = 1'b1;
    logic read_enable_n = 1'b1;
    logic output_enable_n = 1'b0;
    logic offset_load_n = 1'b1;
    logic replay = 1'b0;
    logic sync_sel_n = 1'b1;
    logic depth_expand = 1'b0;
    logic first_load_n = 1'b0;
    logic push_token_in = 1'b0;
    logic pop_token_in = 1'b0;
    logic [fifo_pkg::DATA_W-1:0] data = 18'h0_0000;
    logic [fifo_pkg::DATA_W-1:0] data_o;
    logic [fifo_pkg::DATA_W-1:0] bus;
    logic data_oe_o, full_n, empty_n, ae_n, af_n, hf_n, pop_out, push_out;
    int fail_count = 0;
    int checked = 0;

    always #50 clk_sys_i = ~clk_sys_i;

    dual_clock_fifo_prog_flags u_dual_clock_fifo_prog_flags (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .write_enable_n_i(write_enable_n),
        .data_i(data),
        .read_enable_n_i(read_enable_n),
        .output_enable_n_i(output_enable_n),
        .offset_load_n_i(offset_load_n),
        .replay_strobe_i(replay),
        .flag_sync_select_n_i(sync_sel_n),
        .depth_expand_i(depth_expand),
        .first_load_n_i(first_load_n),
        .push_token_in_i(push_token_in),
        .pop_token_in_i(pop_token_in),
        .data_o(data_o),
        .data_oe_o(data_oe_o),
        .full_flag_n_o(full_n),
        .empty_flag_n_o(empty_n),
        .almost_empty_n_o(ae_n),
        .almost_full_n_o(af_n),
        .half_full_n_o(hf_n),
        .push_token_out_o(push_out),
        .pop_token_out_o(pop_out)
    );

    output_bus_model u_output_bus_model (
        .clk_sys_i(clk_sys_i),
        .data_i(data_o),
        .drive_i(data_oe_o),
        .bus_o(bus)
    );

    // ==========================================================
    // Checking and closing
    task automatic chk_word(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Access tasks, all driven on the falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic fill(input int n, input logic [17:0] base);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk_sys_i);
            write_enable_n = 1'b0;
            data = base + 18'(i);
        end
        @(negedge clk_sys_i);
        write_enable_n = 1'b1;
    endtask

    // Each word is checked one edge after the read that fetched it.
    task automatic drain(input int n, input logic [17:0] base);
        for (int i = 0; i <= n; i++)
        begin
            @(negedge clk_sys_i);
            read_enable_n = (i == n);
            if (i > 0)
                chk_word(bus, base + 18'(i - 1));
        end
    endtask

    // Reads and writes stay idle while reset is applied.
    task automatic reset_dut();
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        @(negedge clk_sys_i);
        rst_i = 1'b0;
    endtask

    initial
    begin
        #4000000;
        fail_count++;
        print_verdict();
    end

    // ==========================================================
    // Test sequence
    initial
    begin
        cyc(16);
        rst_i = 1'b0;
        cyc(2);
        chk_bit(empty_n, 1'b0);
        chk_bit(full_n, 1'b1);
        chk_bit(ae_n, 1'b0);
        chk_bit(af_n, 1'b1);
        chk_word(bus, 18'h0_0000);
        $display("test reset done");

        offset_load_n = 1'b0;
        drain(1, 18'h0_007f);
        drain(1, 18'h0_007f);
        fill(2, 18'h3_0005);
        offset_load_n = 1'b1;
        cyc(1);
        offset_load_n = 1'b0;
        fill(1, 18'h0_0003);
        drain(1, 18'h0_0003);
        drain(1, 18'h0_0006);
        offset_load_n = 1'b1;
        chk_bit(empty_n, 1'b0);
        $display("test offsets done");

        fill(3, 18'h0_0100);
        chk_bit(ae_n, 1'b0);
        chk_bit(empty_n, 1'b1);
        fill(1, 18'h0_0103);
        chk_bit(ae_n, 1'b1);
        drain(4, 18'h0_0100);
        chk_bit(empty_n, 1'b0);
        drain(1, 18'h0_0103);
        output_enable_n = 1'b1;
        cyc(2);
        chk_bit(data_oe_o, 1'b0);
        output_enable_n = 1'b0;
        sync_sel_n = 1'b0;
        cyc(2);
        fill(4, 18'h0_0110);
        chk_bit(ae_n, 1'b0);
        cyc(1);
        chk_bit(ae_n, 1'b1);
        sync_sel_n = 1'b1;
        $display("test data and flags done");

        reset_dut();
        fill(4, 18'h0_0200);
        drain(1, 18'h0_0200);
        // Replay is pulsed with both enables idle around it.
        @(negedge clk_sys_i);
        replay = 1'b1;
        @(negedge clk_sys_i);
        replay = 1'b0;
        cyc(1);
        chk_bit(empty_n, 1'b1);
        drain(4, 18'h0_0200);
        chk_bit(empty_n, 1'b0);
        $display("test replay done");

        reset_dut();
        fill(4096, 18'h0_0000);
        chk_bit(hf_n, 1'b1);
        fill(1, 18'h0_1000);
        chk_bit(hf_n, 1'b0);
        fill(3967, 18'h0_1001);
        chk_bit(af_n, 1'b1);
        fill(1, 18'h0_1f80);
        chk_bit(af_n, 1'b0);
        fill(127, 18'h0_1f81);
        chk_bit(full_n, 1'b0);
        fill(1, 18'h3_ffff);
        chk_bit(full_n, 1'b0);
        drain(8192, 18'h0_0000);
        chk_bit(empty_n, 1'b0);
        $display("test full depth done");

        depth_expand = 1'b1;
        first_load_n = 1'b1;
        reset_dut();
        fill(1, 18'h0_0055);
        chk_bit(empty_n, 1'b0);
        chk_bit(data_oe_o, 1'b0);
        @(negedge clk_sys_i);
        push_token_in = 1'b1;
        pop_token_in = 1'b1;
        @(negedge clk_sys_i);
        push_token_in = 1'b0;
        pop_token_in = 1'b0;
        fill(1, 18'h0_0055);
        chk_bit(empty_n, 1'b1);
        chk_bit(hf_n, 1'b1);
        drain(1, 18'h0_0055);
        chk_bit(pop_out, 1'b1);
        fill(8192, 18'h0_0000);
        chk_bit(push_out, 1'b1);
        chk_bit(full_n, 1'b0);
        chk_bit(hf_n, 1'b1);
        $display("test cascade done");

        print_verdict();
    end
endmodule // dual_clock_fifo_prog_flags_tb_top

// ---- bench/output_bus_model.sv ----
// ==========================================================
// Output bus seen by the reader
module output_bus_model (
    input wire logic clk_sys_i,
    input wire logic [fifo_pkg::DATA_W-1:0] data_i,
    input wire logic drive_i,
    output logic [fifo_pkg::DATA_W-1:0] bus_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [fifo_pkg::DATA_W-1:0] last_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (drive_i)
            last_q <= data_i;
    end

    // float shows garbage
    // A released bus shows the inverse of the last value, so a stale
    // word can never pass for a driven one.
    always_comb
    begin
        bus_o = drive_i ? data_i : ~last_q;
    end
endmodule // output_bus_model

// ---- hw/dual_clock_fifo_prog_flags.sv ----
// Notes on behaviour
// - Each enabled write edge stores the 18-bit input word once.
// - Each enabled read edge presents the next stored word on the outputs.
// - Output enable high floats the outputs; low drives the output register.
// - When empty, outputs keep the last valid read word.
// - Full flag low when full; writes ignored then; updates on write edges.
// - Empty flag low when empty; reads ignored then; updates on read edges.
// - Two 16-bit offset registers loaded from input bits 0 to 15.
// - Both offsets default to 127 words when never programmed.
// - Load low writes alternate empty then full offset; load high writes FIFO.
// - Raising load resumes normal use; next load write continues sequence.
// - Load low reads return offsets in the same alternating order.
// - Almost flags low when count or free space is at most offset.
// - Half full low when count exceeds half the depth.
// - Sync flag mode updates almost flags on their own clock edges.
// - Replay pulse returns read pointer to location zero, except in depth expansion where it is ignored; flags recomputed.
// - After replay, reads return old data up to the write pointer.
// - Half full flag not given in depth expansion.
// - In a cascade only the read token holder drives the outputs.
// - Reset empties the FIFO; no reads or writes during reset.
// - Flag mode high makes almost flags follow the level at once.
module dual_clock_fifo_prog_flags (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic write_enable_n_i,
    input wire logic [fifo_pkg::DATA_W-1:0] data_i,
    input wire logic read_enable_n_i,
    input wire logic output_enable_n_i,
    input wire logic offset_load_n_i,
    input wire logic replay_strobe_i,
    input wire logic flag_sync_select_n_i,
    input wire logic depth_expand_i,
    input wire logic first_load_n_i,
    input wire logic push_token_in_i,
    input wire logic pop_token_in_i,
    output logic [fifo_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic full_flag_n_o,
    output logic empty_flag_n_o,
    output logic almost_empty_n_o,
    output logic almost_full_n_o,
    output logic half_full_n_o,
    output logic push_token_out_o,
    output logic pop_token_out_o
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [fifo_pkg::PTR_W-1:0] wptr;
        logic [fifo_pkg::PTR_W-1:0] rptr;
        logic [fifo_pkg::OFF_W-1:0] ae_off;
        logic [fifo_pkg::OFF_W-1:0] af_off;
        fifo_pkg::offset_sel_t wsel;
        fifo_pkg::offset_sel_t rsel;
        logic wtok;
        logic rtok;
        logic push_out;
        logic pop_out;
        logic empty_n;
        logic full_n;
        logic ae_n;
        logic af_n;
        logic hf_n;
        logic oe;
        logic [fifo_pkg::DATA_W-1:0] data;
    } state_t;

    state_t q;
    state_t d;

    // ==========================================================
    // Access decode
    logic do_wr;
    logic do_ld_wr;
    logic do_rd;
    logic do_ld_rd;
    logic replay;
    logic [fifo_pkg::PTR_W-1:0] wptr_next;
    logic [fifo_pkg::PTR_W-1:0] rptr_next;
    logic [fifo_pkg::PTR_W-1:0] count_now;
    logic [fifo_pkg::PTR_W-1:0] count_next;
    logic [fifo_pkg::DATA_W-1:0] rd_data;
    logic ae_async;
    logic af_async;
    logic hf_async;
    logic ae_sync;
    logic af_sync;
    logic hf_sync;
    logic [fifo_pkg::OFF_W-1:0] ae_off_next;
    logic [fifo_pkg::OFF_W-1:0] af_off_next;

    assign do_wr = !write_enable_n_i && offset_load_n_i && q.full_n && q.wtok;
    assign do_ld_wr = !write_enable_n_i && !offset_load_n_i;
    assign do_rd = !read_enable_n_i && offset_load_n_i && q.empty_n && q.rtok;
    assign do_ld_rd = !read_enable_n_i && !offset_load_n_i;
    assign replay = replay_strobe_i && !depth_expand_i;

    assign wptr_next = do_wr ? q.wptr + fifo_pkg::PTR_STEP : q.wptr;
    assign rptr_next = replay ? fifo_pkg::PTR_ZERO
                     : (do_rd ? q.rptr + fifo_pkg::PTR_STEP : q.rptr);
    assign count_now = q.wptr - q.rptr;
    assign count_next = wptr_next - rptr_next;
    assign ae_off_next = (do_ld_wr && q.wsel == fifo_pkg::SEL_EMPTY)
        ? data_i[fifo_pkg::OFF_W-1:0] : q.ae_off;
    assign af_off_next = (do_ld_wr && q.wsel == fifo_pkg::SEL_FULL)
        ? data_i[fifo_pkg::OFF_W-1:0] : q.af_off;

    // ==========================================================
    // Storage and level compare
    fifo_store u_store (
        .clk_sys_i(clk_sys_i),
        .wr_en_i(do_wr),
        .wr_addr_i(q.wptr[fifo_pkg::ADDR_W-1:0]),
        .wr_data_i(data_i),
        .rd_addr_i(q.rptr[fifo_pkg::ADDR_W-1:0]),
        .rd_data_o(rd_data)
    );

    // The free-running mode sees the level that this edge creates.
    level_flags u_async_flags (
        .count_i(count_next),
        .ae_off_i(ae_off_next),
        .af_off_i(af_off_next),
        .almost_empty_n_o(ae_async),
        .almost_full_n_o(af_async),
        .half_over_o(hf_async)
    );

    // Clocked mode lags one edge, as a resampled flag would.
    level_flags u_sync_flags (
        .count_i(count_now),
        .ae_off_i(q.ae_off),
        .af_off_i(q.af_off),
        .almost_empty_n_o(ae_sync),
        .almost_full_n_o(af_sync),
        .half_over_o(hf_sync)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        d = q;
        d.push_out = 1'b0;
        d.pop_out = 1'b0;
        if (push_token_in_i)
        begin
            d.wtok = 1'b1;
        end
        if (pop_token_in_i)
        begin
            d.rtok = 1'b1;
        end
        d.wptr = wptr_next;
        d.rptr = rptr_next;
        if (do_ld_wr)
        begin
            if (q.wsel == fifo_pkg::SEL_EMPTY)
            begin
                d.ae_off = data_i[fifo_pkg::OFF_W-1:0];
                d.wsel = fifo_pkg::SEL_FULL;
            end
            else
            begin
                d.af_off = data_i[fifo_pkg::OFF_W-1:0];
                d.wsel = fifo_pkg::SEL_EMPTY;
            end
        end
        if (do_rd && !replay)
        begin
            d.data = rd_data;
        end
        if (do_ld_rd)
        begin
            if (q.rsel == fifo_pkg::SEL_EMPTY)
            begin
                d.data = {fifo_pkg::OFF_PAD, q.ae_off};
                d.rsel = fifo_pkg::SEL_FULL;
            end
            else
            begin
                d.data = {fifo_pkg::OFF_PAD, q.af_off};
                d.rsel = fifo_pkg::SEL_EMPTY;
            end
        end
        if (depth_expand_i && do_wr && count_next == fifo_pkg::DEPTH)
        begin
            d.wtok = 1'b0;
            d.push_out = 1'b1;
        end
        if (depth_expand_i && do_rd && count_next == fifo_pkg::PTR_ZERO)
        begin
            d.rtok = 1'b0;
            d.pop_out = 1'b1;
        end
        d.full_n = count_next != fifo_pkg::DEPTH;
        d.empty_n = count_next != fifo_pkg::PTR_ZERO;
        d.hf_n = depth_expand_i || !hf_async;
        if (flag_sync_select_n_i)
        begin
            d.ae_n = ae_async;
            d.af_n = af_async;
        end
        else
        begin
            d.ae_n = ae_sync;
            d.af_n = af_sync;
        end
        d.oe = !output_enable_n_i && (!depth_expand_i || q.rtok);
        if (rst_i)
        begin
            d.wptr = fifo_pkg::PTR_ZERO;
            d.rptr = fifo_pkg::PTR_ZERO;
            d.ae_off = fifo_pkg::OFF_RESET;
            d.af_off = fifo_pkg::OFF_RESET;
            d.wsel = fifo_pkg::SEL_EMPTY;
            d.rsel = fifo_pkg::SEL_EMPTY;
            d.wtok = !depth_expand_i || !first_load_n_i;
            d.rtok = !depth_expand_i || !first_load_n_i;
            d.push_out = 1'b0;
            d.pop_out = 1'b0;
            d.empty_n = 1'b0;
            d.full_n = 1'b1;
            d.ae_n = 1'b0;
            d.af_n = 1'b1;
            d.hf_n = 1'b1;
            d.oe = 1'b0;
            d.data = fifo_pkg::DATA_RESET;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        q <= d;
    end

    // ==========================================================
    // Outputs
    assign data_o = q.data;
    assign data_oe_o = q.oe;
    assign full_flag_n_o = q.full_n;
    assign empty_flag_n_o = q.empty_n;
    assign almost_empty_n_o = q.ae_n;
    assign almost_full_n_o = q.af_n;
    assign half_full_n_o = q.hf_n;
    assign push_token_out_o = q.push_out;
    assign pop_token_out_o = q.pop_out;

    // ==========================================================
    // Checks
    // write advances pointer
    write_store_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        do_wr |=> q.wptr == $past(q.wptr) + fifo_pkg::PTR_STEP
    ) else $error("Write did not advance the write pointer.");

    read_present_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        do_rd && !replay |=> data_o == $past(rd_data)
    ) else $error("Read did not present the stored word.");

    oe_follow_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !depth_expand_i |=> data_oe_o == !$past(output_enable_n_i)
    ) else $error("Output enable did not follow its pin.");

    empty_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !empty_flag_n_o && offset_load_n_i |=> $stable(data_o)
    ) else $error("Data changed while the FIFO was empty.");

    full_block_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !full_flag_n_o |=> $stable(q.wptr)
    ) else $error("Write accepted while full.");

    empty_block_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !empty_flag_n_o && !replay |=> $stable(q.rptr)
    ) else $error("Read accepted while empty.");

    offset_default_a: assert property (
        @(posedge clk_sys_i)
        rst_i |=> q.ae_off == fifo_pkg::OFF_RESET
            && q.af_off == fifo_pkg::OFF_RESET
    ) else $error("Offsets not at their default after reset.");

    load_alternate_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        do_ld_wr ##1 do_ld_wr |=> q.wsel == $past(q.wsel, 2)
    ) else $error("Offset write sequence did not alternate.");

    ae_async_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        flag_sync_select_n_i |=>
            almost_empty_n_o == ({fifo_pkg::CNT_PAD, count_now} > q.ae_off)
    ) else $error("Almost empty flag wrong in free mode.");

    af_sync_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !flag_sync_select_n_i |=> almost_full_n_o ==
            ({fifo_pkg::CNT_PAD, fifo_pkg::DEPTH - $past(count_now)}
             > $past(q.af_off))
    ) else $error("Almost full flag wrong in clocked mode.");

    half_flag_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !$past(depth_expand_i) |->
            half_full_n_o == !(count_now > fifo_pkg::HALF)
    ) else $error("Half full flag disagrees with the level.");

    replay_ptr_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        replay |=> q.rptr == fifo_pkg::PTR_ZERO
    ) else $error("Replay did not rewind the read pointer.");

    token_pass_a: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        push_token_out_o |-> !q.wtok && count_now == fifo_pkg::DEPTH
    ) else $error("Push token passed without filling.");

endmodule // dual_clock_fifo_prog_flags

// ---- hw/fifo_pkg.sv ----
package fifo_pkg;

    // ==========================================================
    // Widths and depth
    localparam int DATA_W = 18;
    localparam int OFF_W = 16;
    localparam int ADDR_W = 13;
    localparam int PTR_W = 14;
    localparam int WORDS = 8192;

    // ==========================================================
    // Pointer and level constants
    localparam logic [PTR_W-1:0] DEPTH = 14'h2000;
    localparam logic [PTR_W-1:0] HALF = 14'h1000;
    localparam logic [PTR_W-1:0] PTR_STEP = 14'h0001;
    localparam logic [PTR_W-1:0] PTR_ZERO = 14'h0000;
    localparam logic [OFF_W-PTR_W-1:0] CNT_PAD = 2'h0;

    // ==========================================================
    // Offset registers
    localparam logic [OFF_W-1:0] OFF_RESET = 16'h007f;
    localparam logic [DATA_W-OFF_W-1:0] OFF_PAD = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 18'h0_0000;

    // Which offset register the next load-mode access reaches.
    typedef enum logic [0:0] {
        SEL_EMPTY = 1'b0,
        SEL_FULL = 1'b1
    } offset_sel_t;

endpackage

// ---- hw/fifo_store.sv ----
module fifo_store (
    input wire logic clk_sys_i,
    input wire logic wr_en_i,
    input wire logic [fifo_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic [fifo_pkg::DATA_W-1:0] wr_data_i,
    input wire logic [fifo_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [fifo_pkg::DATA_W-1:0] rd_data_o
);

    // ==========================================================
    // Storage array
    // The array has no reset; words are only read after a write.
    logic [fifo_pkg::DATA_W-1:0] mem_q [0:fifo_pkg::WORDS-1];

    always_ff @(posedge clk_sys_i)
    begin
        if (wr_en_i)
        begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem_q[rd_addr_i];

endmodule // fifo_store

// ---- hw/level_flags.sv ----
module level_flags (
    input wire logic [fifo_pkg::PTR_W-1:0] count_i,
    input wire logic [fifo_pkg::OFF_W-1:0] ae_off_i,
    input wire logic [fifo_pkg::OFF_W-1:0] af_off_i,
    output logic almost_empty_n_o,
    output logic almost_full_n_o,
    output logic half_over_o
);

    // ==========================================================
    // Level compare
    logic [fifo_pkg::PTR_W-1:0] free;

    assign free = fifo_pkg::DEPTH - count_i;
    assign almost_empty_n_o = !({fifo_pkg::CNT_PAD, count_i} <= ae_off_i);
    assign almost_full_n_o = !({fifo_pkg::CNT_PAD, free} <= af_off_i);
    assign half_over_o = count_i > fifo_pkg::HALF;

endmodule // level_flags
